// ===== hdl/sadc_params.svh
// constants for the serial converter link
`ifndef SADC_PARAMS_SVH
`define SADC_PARAMS_SVH
`define SADC_CLK_NS        10
`define SADC_CS_QUAL_NS    1425
`define SADC_CS_QUAL_CYC   ((`SADC_CS_QUAL_NS + `SADC_CLK_NS - 1) / `SADC_CLK_NS)
`define SADC_ABORT_NS      9000
`define SADC_ABORT_CYC     (`SADC_ABORT_NS / `SADC_CLK_NS)
`define SADC_CONV_NS       21000
`define SADC_CONV_CYC      (`SADC_CONV_NS / `SADC_CLK_NS)
`define SADC_ADDR_BITS     4
`define SADC_RES_BITS      10
`define SADC_XFER_CLKS     10
`define SADC_MAX_CLKS      16
`define SADC_TEST_A        4'hb
`define SADC_TEST_B        4'hc
`define SADC_TEST_C        4'hd
`define SADC_CODE_A        10'h200
`define SADC_CODE_B        10'h000
`define SADC_CODE_C        10'h3ff
`define SADC_SCLK_DIV      6
`define SADC_FIFO_DEPTH    8
`endif

// ===== hdl/sadc_pkg.sv
// shared types for the serial converter link
package sadc_pkg;
   typedef logic [3:0] sadc_addr_t;
   typedef logic [9:0] sadc_res_t;
endpackage

// ===== hdl/sadc_if.sv
// serial link between host and converter
`timescale 1ns/1ps
interface sadc_if;
   logic cs_n;       // chip select, active low
   logic sclk;       // transfer clock from host
   logic addr;       // channel address bit
   logic dout;       // data out value
   logic dout_oe;    // data out enable
   logic eoc;        // end of conversion
   modport dev  (input cs_n, sclk, addr, output dout, dout_oe, eoc);
   modport host (input dout, dout_oe, eoc, output cs_n, sclk, addr);
endinterface

// ===== hdl/sadc_fifo.sv
// small valid/ready fifo
`timescale 1ns/1ps
module sadc_fifo #(
   parameter int W = 10,
   parameter int D = 8
) (
   input  wire logic         clk_i,      // clock
   input  wire logic         reset_n_i,  // async reset
   input  wire logic [W-1:0] in_data_i,  // write data
   input  wire logic         in_valid_i, // write valid
   output logic              in_ready_o, // not full
   output logic [W-1:0]      out_data_o, // head word
   output logic              out_valid_o,// not empty
   input  wire logic         out_ready_i // reader takes
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW:0]  wp;
   logic [AW:0]  rp;
   logic         wr;
   logic         rd;
   assign wr = in_valid_i && in_ready_o;
   assign rd = out_valid_o && out_ready_i;
   assign in_ready_o  = (wp - rp) != (AW+1)'(D);
   assign out_valid_o = wp != rp;
   assign out_data_o  = mem[rp[AW-1:0]];
   // pointer updates
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wp <= '0;
         rp <= '0;
      end else begin
         if (wr) wp <= wp + 1'b1;
         if (rd) rp <= rp + 1'b1;
      end
   end
   // storage
   always_ff @(posedge clk_i) begin
      if (wr) mem[wp[AW-1:0]] <= in_data_i;
   end
endmodule

// ===== hdl/sadc_dev.sv
// converter end: select filter, shifter, conversion timer
// Operation
// - select change valid after qualification time
// - ignore address and clock until qualified
// - host waits setup before shifting address
// - select high disables address and clock
// - early select fall aborts conversion
// - select fall drives result MSB
// - select rise floats data output
// - ten clock transfers, select toggled or held
// - eleven to sixteen clocks with select
// - no-select short mode waits for eoc
// - eleventh rising edge before conversion ends
// - no-select long mode exactly sixteen clocks
// - eoc falls after tenth falling clock
// - address and codes are positive logic
// - codes b,c,d select self-test values
`timescale 1ns/1ps
`include "sadc_params.svh"
module sadc_dev (
   input  wire logic         clk_i,      // system clock
   input  wire logic         reset_n_i,  // async reset
   sadc_if.dev               lnk,        // serial link
   input  wire sadc_pkg::sadc_res_t ain_code_i [11], // channel samples
   output logic              busy_o,     // conversion running
   output sadc_pkg::sadc_addr_t chan_o   // channel converting
);
   import sadc_pkg::*;
   typedef enum {ST_IDLE, ST_CONV} sadc_st_e;
   logic [1:0]  cs_s;
   logic [1:0]  ck_s;
   logic [1:0]  ad_s;
   logic        cs_q;
   logic [11:0] cs_cnt;
   logic        ck_d;
   logic        eoc_d;
   logic [4:0]  nclk;
   sadc_addr_t  ash;
   sadc_res_t   osh;
   sadc_res_t   res;
   sadc_st_e    st;
   logic [15:0] tcnt;
   logic [15:0] ab_cnt;
   logic        dout;
   logic        oe;
   logic        eoc;
   logic        rise;
   logic        fall;
   logic        act;
   assign act  = !cs_q;
   assign rise = act && ck_s[1] && !ck_d;
   assign fall = act && !ck_s[1] && ck_d;
   // two-flop synchronisers
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cs_s <= 2'h3;
         ck_s <= 2'h0;
         ad_s <= 2'h0;
         ck_d <= 1'b0;
         eoc_d <= 1'b1;
      end else begin
         cs_s <= {cs_s[0], lnk.cs_n};
         ck_s <= {ck_s[0], lnk.sclk};
         ad_s <= {ad_s[0], lnk.addr};
         ck_d <= ck_s[1];
         eoc_d <= eoc;
      end
   end
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cs_q   <= 1'b1;
         cs_cnt <= '0;
      end else if (cs_s[1] == cs_q) begin
         cs_cnt <= '0;
      end else if (cs_cnt >= 12'(`SADC_CS_QUAL_CYC - 1)) begin
         cs_q   <= cs_s[1];
         cs_cnt <= '0;
      end else begin
         cs_cnt <= cs_cnt + 12'h001;
      end
   end
   // address in, result out; gated by act
   // held-select cycles restart their count when a conversion ends
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         nclk <= '0;
         ash  <= '0;
         osh  <= '0;
      end else if (!act || (eoc && !eoc_d)) begin
         nclk <= '0;
         osh  <= res;
      end else begin
         if (rise && nclk < 5'(`SADC_ADDR_BITS))
            ash <= {ash[2:0], ad_s[1]};
         if (fall) begin
            osh  <= {osh[8:0], 1'b0};
            nclk <= (nclk == 5'(`SADC_MAX_CLKS)) ? 5'h01 : nclk + 5'h01;
         end
      end
   end
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         dout <= 1'b0;
         oe   <= 1'b0;
      end else begin
         oe   <= act;
         dout <= osh[9];
      end
   end
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st     <= ST_IDLE;
         tcnt   <= '0;
         ab_cnt <= '0;
         eoc    <= 1'b1;
         res    <= '0;
         chan_o <= '0;
      end else begin
         unique case (st)
            ST_IDLE: begin
               if (fall && nclk == 5'(`SADC_XFER_CLKS - 1)) begin
                  st     <= ST_CONV;
                  eoc    <= 1'b0;
                  tcnt   <= '0;
                  ab_cnt <= '0;
                  chan_o <= ash;
               end
            end
            ST_CONV: begin
               tcnt <= tcnt + 16'h0001;
               if (ab_cnt < 16'(`SADC_ABORT_CYC))
                  ab_cnt <= ab_cnt + 16'h0001;
               if (cs_q && !cs_s[1] && ab_cnt < 16'(`SADC_ABORT_CYC)) begin
                  st  <= ST_IDLE;
                  eoc <= 1'b1;
               end else if (tcnt >= 16'(`SADC_CONV_CYC - 1)) begin
                  st  <= ST_IDLE;
                  eoc <= 1'b1;
                  unique case (chan_o)
                     `SADC_TEST_A: res <= `SADC_CODE_A;
                     `SADC_TEST_B: res <= `SADC_CODE_B;
                     `SADC_TEST_C: res <= `SADC_CODE_C;
                     default:
                        res <= (chan_o < 4'hb) ? ain_code_i[chan_o] : `SADC_CODE_B;
                  endcase
               end
            end
         endcase
      end
   end
   assign lnk.dout    = dout;
   assign lnk.dout_oe = oe;
   assign lnk.eoc     = eoc;
   // registered busy flag
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         busy_o <= 1'b0;
      end else begin
         busy_o <= !eoc;
      end
   end
endmodule

// ===== hdl/sadc_host.sv
// host end: drives select, clock, address; collects results
`timescale 1ns/1ps
`include "sadc_params.svh"
module sadc_host (
   input  wire logic         clk_i,      // system clock
   input  wire logic         reset_n_i,  // async reset
   sadc_if.host              lnk,        // serial link
   input  wire logic         start_i,    // begin one transfer
   input  wire sadc_pkg::sadc_addr_t chan_i, // next channel
   input  wire logic [4:0]   nclk_i,     // clocks per transfer 10..16
   input  wire logic         use_cs_i,   // frame with select
   output logic              busy_o,     // transfer running
   output sadc_pkg::sadc_res_t res_o,    // result word
   output logic              res_valid_o,// result available
   input  wire logic         res_ready_i // result taken
);
   import sadc_pkg::*;
   typedef enum {H_IDLE, H_SETUP, H_SHIFT, H_HOLD} sadc_hst_e;
   sadc_hst_e   st;
   logic [1:0]  eo_s;
   logic [1:0]  do_s;
   logic [11:0] cnt;
   logic [2:0]  div;
   logic [4:0]  n;
   logic [4:0]  nt;
   logic [15:0] sh;
   logic [9:0]  rx;
   logic        cs_n;
   logic        sclk;
   logic        fpush;
   logic        fpop;
   logic        fready;
   logic        fvalid;
   sadc_res_t   fdata;
   // sync device outputs
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         eo_s <= 2'h0;
         do_s <= 2'h0;
      end else begin
         eo_s <= {eo_s[0], lnk.eoc};
         do_s <= {do_s[0], lnk.dout};
      end
   end
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st <= H_IDLE; cs_n <= 1'b1; sclk <= 1'b0; cnt <= '0; div <= '0;
         n <= '0; nt <= 5'h0a; sh <= '0; rx <= '0; fpush <= 1'b0;
      end else begin
         fpush <= 1'b0;
         unique case (st)
            H_IDLE: if (start_i && fready && eo_s[1]) begin
               st <= H_SETUP; cs_n <= 1'b0; cnt <= '0;
               nt <= (nclk_i < 5'h0a) ? 5'h0a : (nclk_i > 5'h10 ? 5'h10 : nclk_i);
               if (!use_cs_i && nclk_i > 5'h0a) nt <= 5'h10;
               sh <= {chan_i, 12'h000}; n <= '0; div <= '0; rx <= '0;
            end
            H_SETUP: begin
               cs_n <= 1'b0;
               cnt <= cnt + 12'h001;
               if (cnt >= 12'(`SADC_CS_QUAL_CYC + 4)) st <= H_SHIFT;
            end
            H_SHIFT: begin
               div <= (div == 3'(`SADC_SCLK_DIV - 1)) ? 3'h0 : div + 3'h1;
               if (div == 3'(`SADC_SCLK_DIV - 1)) begin
                  sclk <= !sclk;
                  // sample just before each fall; only ten result bits
                  if (sclk) begin
                     if (n < 5'h0a) rx <= {rx[8:0], do_s[1]};
                     sh <= {sh[14:0], 1'b0};
                     n  <= n + 5'h01;
                     if (n + 5'h01 == nt) begin
                        st <= H_HOLD; cnt <= '0; fpush <= 1'b1;
                     end
                  end
               end
            end
            H_HOLD: begin
               cnt <= cnt + 12'h001;
               if (use_cs_i) cs_n <= 1'b1;
               if (cnt >= 12'(`SADC_CS_QUAL_CYC + 4)) st <= H_IDLE;
            end
         endcase
      end
   end
   assign lnk.cs_n = cs_n;
   assign lnk.sclk = sclk;
   assign lnk.addr = sh[15];
   // result fifo, reader back-pressure stalls new transfers
   sadc_fifo #(.W(10), .D(`SADC_FIFO_DEPTH)) u_fifo (
      .clk_i      (clk_i),
      .reset_n_i  (reset_n_i),
      .in_data_i  (rx),
      .in_valid_i (fpush),
      .in_ready_o (fready),
      .out_data_o (fdata),
      .out_valid_o(fvalid),
      .out_ready_i(fpop)
   );
   // output stage refills when empty or being taken
   assign fpop = fvalid && (!res_valid_o || res_ready_i);
   // registered outputs
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         busy_o <= 1'b0; res_o <= '0; res_valid_o <= 1'b0;
      end else begin
         busy_o <= st != H_IDLE;
         if (fpop) begin
            res_o <= fdata;
            res_valid_o <= 1'b1;
         end else if (res_ready_i) begin
            res_valid_o <= 1'b0;
         end
      end
   end
endmodule

// ===== test/sadc_properties.sv
// link property checker
`timescale 1ns/1ps
module sadc_properties (
   input  wire logic clk_i,     // clock
   input  wire logic reset_n_i, // reset
   input  wire logic cs_n,      // select
   input  wire logic sclk,      // link clock
   input  wire logic addr,      // address
   input  wire logic dout,      // data
   input  wire logic dout_oe,   // data enable
   input  wire logic eoc        // done
);
   logic [4:0]  nrise;
   logic [11:0] ec;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   // link clock rises since deselect or eoc rise
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         nrise <= '0;
      end else if (cs_n || $rose(eoc)) begin
         nrise <= '0;
      end else if ($rose(sclk)) begin
         nrise <= nrise + 5'h01;
      end
   end
   // cycles spent converting
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ec <= '0;
      end else if (eoc) begin
         ec <= '0;
      end else if (ec != 12'hfff) begin
         ec <= ec + 12'h001;
      end
   end
   a_no_early_drive: assert property ($fell(cs_n) |-> !dout_oe throughout ##135 1'b1)
      else $error("data driven too early");
   a_setup_quiet: assert property ($fell(cs_n) |-> !sclk throughout ##143 1'b1)
      else $error("clock during setup");
   a_clk_idle: assert property (cs_n |-> !sclk)
      else $error("clock while deselected");
   a_drive_msb: assert property ($fell(cs_n) |-> ##160 dout_oe)
      else $error("data not driven");
   a_float_off: assert property ($rose(cs_n) |-> ##160 !dout_oe)
      else $error("data not floated");
   a_frame_pulses: assert property ($rose(cs_n) |-> nrise >= 5'h0a && nrise <= 5'h10)
      else $error("bad pulse count");
   a_nocs_pulses: assert property ($rose(eoc) && !cs_n |-> nrise == 5'h0a || nrise == 5'h10)
      else $error("bad pulse count without select");
   a_addr_steady: assert property (sclk && $past(sclk) |-> $stable(addr))
      else $error("address moved while clock high");
   a_first_ten_eoc: assert property ($rose(sclk) && nrise < 5'h0a |-> eoc)
      else $error("clock during conversion");
   a_eoc_after_tenth: assert property ($fell(sclk) && nrise == 5'h0a |-> ##[1:30] !eoc)
      else $error("eoc late");
   a_conv_span: assert property ($rose(eoc) |-> ec >= 12'h82a && ec <= 12'h83e)
      else $error("conversion length");
endmodule

// ===== test/testbench.sv
// bench: host and converter face to face
`timescale 1ns/1ps
`include "sadc_params.svh"
module testbench;
   import sadc_pkg::*;
   logic       clk_i = 1'b0;
   logic       reset_n_i = 1'b0;
   logic       start_i = 1'b0;
   logic       use_cs_i = 1'b1;
   logic       res_ready_i = 1'b0;
   logic       rnd = 1'b0;
   logic       busy_o;
   logic       res_valid_o;
   logic [4:0] nclk_i = 5'h0a;
   logic [7:0] lf = 8'h2c;
   logic [7:0] lr = 8'h2c;
   sadc_addr_t chan_i = '0;
   sadc_addr_t prev;
   sadc_addr_t dchan;
   logic       dbusy;
   sadc_res_t  ain [11];
   sadc_res_t  res_o;
   sadc_res_t  exp_q [$];
   int         n_errors = 0;
   int         checks = 0;
   int         taken = 0;
   bit         first = 1'b1;
   bit         drop = 1'b1;
   sadc_if lnk_if();
   sadc_dev sadc_dev_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .lnk(lnk_if), .ain_code_i(ain),
      .busy_o(dbusy), .chan_o(dchan));
   sadc_host sadc_host_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .lnk(lnk_if), .start_i(start_i),
      .chan_i(chan_i), .nclk_i(nclk_i), .use_cs_i(use_cs_i), .busy_o(busy_o), .res_o(res_o),
      .res_valid_o(res_valid_o), .res_ready_i(res_ready_i));
   sadc_properties sadc_properties_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .cs_n(lnk_if.cs_n),
      .sclk(lnk_if.sclk), .addr(lnk_if.addr), .dout(lnk_if.dout), .dout_oe(lnk_if.dout_oe),
      .eoc(lnk_if.eoc));
   always #5 clk_i = ~clk_i;
   function automatic logic [7:0] step(logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   // result expected for a channel
   function automatic sadc_res_t expv(sadc_addr_t c);
      case (c)
         `SADC_TEST_A: return `SADC_CODE_A;
         `SADC_TEST_B: return `SADC_CODE_B;
         `SADC_TEST_C: return `SADC_CODE_C;
         default: return (c > 4'ha) ? 10'h000 : ain[c];
      endcase
   endfunction
   task automatic cmp_res(sadc_res_t e, sadc_res_t s);
      checks++;
      if (s !== e) begin
         n_errors++;
         $display("Error res_o expected %h seen %h", e, s);
      end
   endtask
   task automatic cmp_chan(sadc_addr_t e, sadc_addr_t s);
      checks++;
      if (s !== e) begin
         n_errors++;
         $display("Error chan_o expected %h seen %h", e, s);
      end
   endtask
   task automatic cmp_bit(string name, logic e, logic s);
      checks++;
      if (s !== e) begin
         n_errors++;
         $display("Error %s expected %b seen %b", name, e, s);
      end
   endtask
   task automatic tally_and_finish;
      if (n_errors == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // one transfer; notes the result the previous channel owes
   task automatic xfer(sadc_addr_t c, logic [4:0] n, logic cs);
      int k;
      @(posedge clk_i);
      #1;
      chan_i = c;
      nclk_i = n;
      use_cs_i = cs;
      start_i = 1'b1;
      for (k = 0; k < 3000 && busy_o !== 1'b1; k++) begin
         @(posedge clk_i);
         #1;
      end
      start_i = 1'b0;
      if (busy_o === 1'b1) begin
         if (!first) exp_q.push_back(expv(prev));
         first = 1'b0;
         prev = c;
         taken++;
         for (k = 0; k < 3000 && busy_o !== 1'b0; k++) begin
            @(posedge clk_i);
            #1;
         end
         cmp_bit("dev_busy", 1'b1, dbusy);
         cmp_chan(c, dchan);
      end
   endtask
   // reader stalls at random
   always @(posedge clk_i) begin
      #1;
      if (rnd) begin
         lr = step(lr);
         res_ready_i = lr[0];
      end
   end
   // score results leaving the host
   always @(posedge clk_i) begin
      if (res_valid_o === 1'b1 && res_ready_i === 1'b1) begin
         if (drop) begin
            drop = 1'b0;
         end else begin
            cmp_res(exp_q.size() > 0 ? exp_q.pop_front() : 'x, res_o);
         end
      end
   end
   initial begin
      #1000000;
      n_errors++;
      tally_and_finish();
   end
   initial begin
      for (int i = 0; i < 11; i++) begin
         lf = step(lf);
         ain[i] = {lf, lf[7:6]};
      end
      repeat (4) @(posedge clk_i);
      #1;
      reset_n_i = 1'b1;
      repeat (2) @(posedge clk_i);
      // fill the buffer until starts are refused
      for (int i = 0; i < 12; i++) begin
         xfer(i[3:0], 5'h0a + 5'(i % 7), 1'b1);
      end
      cmp_bit("refused", 1'b1, taken > 7 && taken < 12);
      rnd = 1'b1;
      // framed transfers, channels c and d then random channel; random length
      for (int i = 0; i < 6; i++) begin
         lf = step(lf);
         xfer(i < 2 ? 4'hc + 4'(i) : lf[3:0], 5'h0a + 5'(lf[6:4] % 7), 1'b1);
      end
      // select held low
      for (int i = 0; i < 4; i++) begin
         lf = step(lf);
         xfer(lf[3:0], i[0] ? 5'h10 : 5'h0a, 1'b0);
      end
      for (int k = 0; k < 5000 && (exp_q.size() > 0 || res_valid_o !== 1'b0); k++) begin
         @(posedge clk_i);
      end
      cmp_bit("drained", 1'b1, exp_q.size() == 0);
      tally_and_finish();
   end
endmodule
